// ---- hw/prog_stage_pkg.sv ----
// constants and types shared by the programmable threshold stage bank
// assumes one 20 MHz system clock and a 32-bit plain register port
package prog_stage_pkg;

    localparam int NUM_STAGES = 8;
    localparam int NUM_GROUPS = 4;
    localparam int MEAS_W = 16;
    localparam int SEL_W = 6;
    localparam int TB_W = 3;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // task cycle timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TASK_BASE_MS = 10;
    localparam int TASK_MID_MS = 20;
    localparam int TASK_SLOW_MS = 100;
    localparam int BASE_TICK_CYCLES = CLK_HZ / 1000 * TASK_BASE_MS;
    localparam int MID_DIV = TASK_MID_MS / TASK_BASE_MS;
    localparam int SLOW_DIV = TASK_SLOW_MS / TASK_BASE_MS;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFS = 10'h000;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 10'h004;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 10'h008;
    localparam logic [ADDR_W-1:0] STATE_OFS = 10'h00C;
    localparam int CFG_REGION_BIT = 9;
    localparam int CFG_WORDS = 128;
    localparam int CFG_IDX_W = 7;

    // words inside one stage/group block of four
    localparam logic [1:0] WORD_CFG = 2'h0;
    localparam logic [1:0] WORD_LIMIT = 2'h1;
    localparam logic [1:0] WORD_HYST = 2'h2;
    localparam logic [1:0] WORD_TIMING = 2'h3;

    // field positions
    localparam int EN_LSB = 0;
    localparam int GRP_LSB = 8;
    localparam int MODE_LSB = 0;
    localparam int CYC_LSB = 2;
    localparam int TB_LSB = 4;
    localparam int SELA_LSB = 8;
    localparam int SELB_LSB = 16;
    localparam int DELAY_LSB = 0;
    localparam int FLOOR_LSB = 16;
    localparam int START_EV_LSB = 0;
    localparam int OPER_EV_LSB = 8;

    // reset values
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [NUM_STAGES-1:0] EN_RESET = 8'h00;
    localparam logic [1:0] GRP_RESET = 2'h0;
    localparam logic [2*NUM_STAGES-1:0] MASK_RESET = 16'h0000;

    typedef enum logic [1:0] {
        over_mode,
        under_mode,
        signed_difference_mode,
        absolute_difference_mode
    } cmp_mode_t;

    typedef enum logic [1:0] {
        cycle_10ms,
        cycle_20ms,
        cycle_100ms,
        cycle_spare
    } task_cycle_t;

    typedef enum logic [SEL_W-1:0] {
        q_il1, q_il2, q_il3, q_u12, q_u23, q_u31, q_i0,
        q_ul1, q_ul2, q_ul3, q_u0, q_freq, q_p, q_q, q_s,
        q_cos_phi, q_i0_calc, q_i_pos, q_i_neg, q_i_neg_rel,
        q_i_neg_pu, q_u_pos, q_u_neg, q_u_neg_rel, q_il_avg,
        q_tan_phi, q_p_rms, q_q_rms, q_s_rms,
        phase_one_current_distortion,
        phase_two_current_distortion,
        phase_three_current_distortion,
        q_dist_ua, q_dist_ub, q_dist_uc, q_freq_y, q_freq_z,
        q_il1_avg_rms, q_il2_avg_rms, q_il3_avg_rms,
        q_il_min, q_il_max, q_ull_min, q_ull_max,
        q_uln_min, q_uln_max,
        virtual_analog_input_one, virtual_analog_input_two,
        virtual_analog_input_three, virtual_analog_input_four,
        virtual_analog_input_five,
        q_count
    } qty_t;

    localparam int NUM_QTY = int'(q_count);

endpackage

// ---- hw/threshold_stage.sv ----
// one programmable comparison stage with averaging, hysteresis and delay
// assumes tick_i is a one-cycle pulse at the stage's task cycle
`timescale 1ns/1ps
`default_nettype none
module threshold_stage
    import prog_stage_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic tick_i,
    input wire cmp_mode_t mode_i,
    input wire logic [TB_W-1:0] timebase_i,
    input wire logic signed [MEAS_W-1:0] value_a_i,
    input wire logic signed [MEAS_W-1:0] value_b_i,
    input wire logic signed [MEAS_W-1:0] limit_i,
    input wire logic [MEAS_W-1:0] hyst_i,
    input wire logic signed [MEAS_W-1:0] floor_i,
    input wire logic [DLY_W-1:0] delay_i,
    output logic start_o,
    output logic operate_o
);

    localparam int XW = MEAS_W + 2;

    logic signed [MEAS_W-1:0] avg_ff;
    logic [DLY_W-1:0] cnt_ff;
    logic signed [MEAS_W:0] avg_err;
    logic signed [MEAS_W:0] avg_step;
    logic signed [MEAS_W:0] nxt_avg;
    logic signed [MEAS_W-1:0] primary;
    logic signed [XW-1:0] prim_x;
    logic signed [XW-1:0] diff_x;
    logic signed [XW-1:0] abs_x;
    logic signed [XW-1:0] lim_x;
    logic signed [XW-1:0] lim_lo;
    logic signed [XW-1:0] lim_hi;
    logic signed [XW-1:0] floor_x;
    logic over_hit;
    logic under_hit;
    logic diff_hit;
    logic abs_hit;
    logic cond;
    logic [DLY_W-1:0] nxt_cnt;
    logic nxt_operate;

    // running average, shift 0 means latest value
    assign avg_err = MEAS_W'(0) + value_a_i - avg_ff;
    assign avg_step = avg_err >>> timebase_i;
    assign nxt_avg = avg_ff + avg_step;
    assign primary = (timebase_i == '0) ? value_a_i : avg_ff;

    assign prim_x = XW'(primary);
    assign diff_x = prim_x - XW'(value_b_i);
    assign abs_x = diff_x[XW-1] ? -diff_x : diff_x;
    assign lim_x = XW'(limit_i);
    assign lim_lo = lim_x - XW'({1'b0, hyst_i});
    assign lim_hi = lim_x + XW'({1'b0, hyst_i});
    assign floor_x = XW'(floor_i);

    // once started, release needs the dead band crossed, the value below the floor (under) or the difference at or below zero (signed difference)
    assign over_hit = start_o ? (prim_x > lim_lo) : (prim_x > lim_x);
    assign under_hit = (prim_x >= floor_x)
        && (start_o ? (prim_x < lim_hi) : (prim_x < lim_x));
    assign diff_hit = (diff_x > 0)
        && (start_o ? (diff_x > lim_lo) : (diff_x > lim_x));
    assign abs_hit = start_o ? (abs_x > lim_lo) : (abs_x > lim_x);

    always_comb
    begin
        unique case (mode_i)
            over_mode: cond = over_hit;
            under_mode: cond = under_hit;
            signed_difference_mode: cond = diff_hit;
            absolute_difference_mode: cond = abs_hit;
        endcase
    end

    // ticks since start, saturating
    assign nxt_cnt = !start_o ? '0 :
        (cnt_ff == '1) ? cnt_ff : cnt_ff + 1'b1;
    assign nxt_operate = cond && (nxt_cnt >= delay_i);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            avg_ff <= '0;
        else if (tick_i)
            avg_ff <= nxt_avg[MEAS_W-1:0];
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            start_o <= 1'b0;
            operate_o <= 1'b0;
            cnt_ff <= '0;
        end
        else if (!enable_i)
        begin
            start_o <= 1'b0;
            operate_o <= 1'b0;
            cnt_ff <= '0;
        end
        else if (tick_i)
        begin
            start_o <= cond;
            operate_o <= nxt_operate;
            cnt_ff <= cond ? nxt_cnt : '0;
        end
    end

endmodule
`default_nettype wire

// ---- hw/programmable_threshold_stages.sv ----
// bank of eight programmable threshold stages with register port and irq
// assumes measurement quantities arrive on the system clock, already scaled
`timescale 1ns/1ps
`default_nettype none

module programmable_threshold_stages
    import prog_stage_pkg::*;
#(
    parameter int BASE_TICK_CYCLES_P = BASE_TICK_CYCLES
)
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [NUM_QTY*MEAS_W-1:0] MEAS_DATA_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    output logic [NUM_STAGES-1:0] START_O,
    output logic [NUM_STAGES-1:0] OPERATE_O,
    output logic IRQ_O
);

    localparam int BW = $clog2(BASE_TICK_CYCLES_P + 1);
    localparam int SW = $clog2(SLOW_DIV + 1);
    localparam int EVW = 2 * NUM_STAGES;

    ////////////////////////////////////////////////////////////////////
    // register state

    logic [DATA_W-1:0] cfg_mem_ff [0:CFG_WORDS-1];
    logic [NUM_STAGES-1:0] enable_ff;
    logic [1:0] group_ff;
    logic [EVW-1:0] irq_stat_ff;
    logic [EVW-1:0] irq_mask_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic irq_ff;
    logic [NUM_STAGES-1:0] start_prev_ff;
    logic [NUM_STAGES-1:0] oper_prev_ff;

    ////////////////////////////////////////////////////////////////////
    // task cycle ticks

    logic [BW-1:0] base_cnt_ff;
    logic base_tick_ff;
    logic [SW-1:0] sub_cnt_ff;
    logic tick_fast;
    logic tick_mid;
    logic tick_slow;
    logic base_wrap;

    assign base_wrap = (base_cnt_ff == BW'(BASE_TICK_CYCLES_P - 1));

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            base_cnt_ff <= '0;
            base_tick_ff <= 1'b0;
        end
        else
        begin
            base_cnt_ff <= base_wrap ? '0 : base_cnt_ff + 1'b1;
            base_tick_ff <= base_wrap;
        end
    end

    // sub counter counts base ticks, ten per slow cycle
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            sub_cnt_ff <= '0;
        else if (base_tick_ff)
            sub_cnt_ff <= (sub_cnt_ff == SW'(SLOW_DIV - 1)) ?
                '0 : sub_cnt_ff + 1'b1;
    end

    assign tick_fast = base_tick_ff;
    assign tick_mid = base_tick_ff
        && (sub_cnt_ff % SW'(MID_DIV) == '0);
    assign tick_slow = base_tick_ff && (sub_cnt_ff == '0);

    ////////////////////////////////////////////////////////////////////
    // register port decode

    // map: 0x000 control, enables in 7:0, active group in 9:8
    // 0x004 sticky events, start rises 7:0, operate rises 15:8, w1c
    // 0x008 event mask, same layout, one enables the interrupt
    // 0x00C stage state, read only, start 7:0 and operate 15:8
    // 0x200 up: settings words, stage 8:6, group 5:4, word 3:2
    // unaligned or unmapped reads give zero, writes are dropped

    logic in_cfg;
    logic [CFG_IDX_W-1:0] cfg_idx;
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic sel_state;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] mask_word;
    logic [DATA_W-1:0] state_word;
    logic [DATA_W-1:0] rd_mux;

    assign in_cfg = REG_ADDR_I[CFG_REGION_BIT];
    assign cfg_idx = REG_ADDR_I[CFG_IDX_W+1:2];
    assign sel_ctrl = !in_cfg && (REG_ADDR_I == CTRL_OFS);
    assign sel_stat = !in_cfg && (REG_ADDR_I == IRQ_STATUS_OFS);
    assign sel_mask = !in_cfg && (REG_ADDR_I == IRQ_MASK_OFS);
    assign sel_state = !in_cfg && (REG_ADDR_I == STATE_OFS);
    assign wr_cfg = REG_WR_I && in_cfg && (REG_ADDR_I[1:0] == 2'h0);
    assign wr_ctrl = REG_WR_I && sel_ctrl;
    assign wr_stat = REG_WR_I && sel_stat;
    assign wr_mask = REG_WR_I && sel_mask;

    assign ctrl_word = {22'h0, group_ff, enable_ff};
    assign stat_word = {16'h0, irq_stat_ff};
    assign mask_word = {16'h0, irq_mask_ff};
    assign state_word = {16'h0, OPERATE_O, START_O};

    assign rd_mux = (in_cfg && REG_ADDR_I[1:0] == 2'h0) ?
        cfg_mem_ff[cfg_idx] :
        sel_ctrl ? ctrl_word :
        sel_stat ? stat_word :
        sel_mask ? mask_word :
        sel_state ? state_word : '0;

    ////////////////////////////////////////////////////////////////////
    // settings memory: stage, group, word

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            for (int i = 0; i < CFG_WORDS; i++)
                cfg_mem_ff[i] <= CFG_RESET;
        end
        else if (wr_cfg)
            cfg_mem_ff[cfg_idx] <= REG_WDATA_I;
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            enable_ff <= EN_RESET;
            group_ff <= GRP_RESET;
        end
        else if (wr_ctrl)
        begin
            enable_ff <= REG_WDATA_I[EN_LSB+:NUM_STAGES];
            group_ff <= REG_WDATA_I[GRP_LSB+:2];
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            irq_mask_ff <= MASK_RESET;
        else if (wr_mask)
            irq_mask_ff <= REG_WDATA_I[EVW-1:0];
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            rdata_ff <= '0;
        else
            rdata_ff <= REG_RD_I ? rd_mux : '0;
    end

    assign REG_RDATA_O = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // stage bank

    logic [NUM_STAGES-1:0] start_w;
    logic [NUM_STAGES-1:0] oper_w;

    generate
        for (genvar s = 0; s < NUM_STAGES; s++)
        begin : g_stage
            logic [CFG_IDX_W-3:0] blk;
            logic [DATA_W-1:0] w_cfg;
            logic [DATA_W-1:0] w_lim;
            logic [DATA_W-1:0] w_hyst;
            logic [DATA_W-1:0] w_tim;
            logic [SEL_W-1:0] sel_a;
            logic [SEL_W-1:0] sel_b;
            logic [1:0] cyc;
            logic diff_mode;
            logic tick;
            cmp_mode_t mode;
            logic signed [MEAS_W-1:0] val_a;
            logic signed [MEAS_W-1:0] val_b;

            // active group chooses the parameter block
            assign blk = {3'(s), group_ff};
            assign w_cfg = cfg_mem_ff[{blk, WORD_CFG}];
            assign w_lim = cfg_mem_ff[{blk, WORD_LIMIT}];
            assign w_hyst = cfg_mem_ff[{blk, WORD_HYST}];
            assign w_tim = cfg_mem_ff[{blk, WORD_TIMING}];

            assign mode = cmp_mode_t'(w_cfg[MODE_LSB+:2]);
            assign cyc = w_cfg[CYC_LSB+:2];
            assign sel_a = w_cfg[SELA_LSB+:SEL_W];
            assign sel_b = w_cfg[SELB_LSB+:SEL_W];
            assign diff_mode = (mode == signed_difference_mode)
                || (mode == absolute_difference_mode);

            // selections off the quantity list read as zero
            assign val_a = (sel_a < SEL_W'(NUM_QTY)) ?
                MEAS_DATA_I[sel_a*MEAS_W+:MEAS_W] : '0;
            assign val_b = (diff_mode
                && sel_b < SEL_W'(NUM_QTY)) ?
                MEAS_DATA_I[sel_b*MEAS_W+:MEAS_W] : '0;

            // spare cycle code runs at the slowest rate
            assign tick = (cyc == 2'(cycle_10ms)) ? tick_fast :
                (cyc == 2'(cycle_20ms)) ? tick_mid : tick_slow;

            threshold_stage u_stage
            (
                .clk_i(SYS_CLK_I),
                .reset_n_i(RESET_N_I),
                .enable_i(enable_ff[s]),
                .tick_i(tick),
                .mode_i(mode),
                .timebase_i(w_cfg[TB_LSB+:TB_W]),
                .value_a_i(val_a),
                .value_b_i(val_b),
                .limit_i(w_lim[MEAS_W-1:0]),
                .hyst_i(w_hyst[MEAS_W-1:0]),
                .floor_i(w_tim[FLOOR_LSB+:MEAS_W]),
                .delay_i(w_tim[DELAY_LSB+:DLY_W]),
                .start_o(start_w[s]),
                .operate_o(oper_w[s])
            );
        end
    endgenerate

    assign START_O = start_w;
    assign OPERATE_O = oper_w;

    ////////////////////////////////////////////////////////////////////
    // events and interrupt

    logic [EVW-1:0] events;
    logic [EVW-1:0] stat_clr;
    logic [EVW-1:0] nxt_irq_stat;
    logic irq_pend;

    assign events = {oper_w & ~oper_prev_ff, start_w & ~start_prev_ff};
    assign stat_clr = wr_stat ? REG_WDATA_I[EVW-1:0] : '0;
    // a new event beats a same-cycle write-one clear
    assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | events;
    // level request from any unmasked sticky bit
    assign irq_pend = |(irq_stat_ff & irq_mask_ff);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            start_prev_ff <= '0;
            oper_prev_ff <= '0;
            irq_stat_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            start_prev_ff <= start_w;
            oper_prev_ff <= oper_w;
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= irq_pend;
        end
    end

    assign IRQ_O = irq_ff;

endmodule
`default_nettype wire

// ---- sim/prog_stage_asserts.sv ----
// port checker for the threshold stage bank
// assumes the bind below attaches it to every bank instance
`timescale 1ns/1ps
`default_nettype none
module prog_stage_asserts
    import prog_stage_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [DATA_W-1:0] REG_RDATA_O,
    input wire logic [NUM_STAGES-1:0] START_O,
    input wire logic [NUM_STAGES-1:0] OPERATE_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    logic [NUM_STAGES-1:0] start_q_ff;
    logic [NUM_STAGES-1:0] oper_q_ff;
    wire rise_ev = |(START_O & ~start_q_ff) || |(OPERATE_O & ~oper_q_ff);
    wire mask_wr = REG_WR_I && REG_ADDR_I == IRQ_MASK_OFS;
    wire bad_addr = REG_ADDR_I[1:0] != 2'h0
        || (!REG_ADDR_I[CFG_REGION_BIT] && REG_ADDR_I > STATE_OFS);
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            start_q_ff <= '0;
            oper_q_ff <= '0;
        end
        else
        begin
            start_q_ff <= START_O;
            oper_q_ff <= OPERATE_O;
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (
        !$past(REG_RD_I) |-> REG_RDATA_O == 32'h0000_0000)
        else $error("read data not zero outside read cycle");
    a_oper_needs_start: assert property (
        (OPERATE_O & ~START_O) == 8'h00)
        else $error("operate without start");
    a_irq_rise_cause: assert property (
        $rose(IRQ_O) |-> $past(rise_ev, 2) || $past(mask_wr, 2))
        else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property (
        $fell(IRQ_O) |-> $past(REG_WR_I, 2))
        else $error("interrupt fell without a write");
    a_state_readback: assert property (
        $past(REG_RD_I && REG_ADDR_I == STATE_OFS) |-> REG_RDATA_O ==
        {16'h0000, $past(OPERATE_O), $past(START_O)})
        else $error("state read differs from outputs");
    a_disable_clears: assert property (
        REG_WR_I && REG_ADDR_I == CTRL_OFS |-> ##2
        ((START_O | OPERATE_O) & ~$past(REG_WDATA_I[7:0], 2)) == 8'h00)
        else $error("disabled stage still active");
    a_unmapped_zero: assert property (
        $past(REG_RD_I && bad_addr) |-> REG_RDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_mask_off_irq: assert property (
        mask_wr && REG_WDATA_I[15:0] == 16'h0000 |-> ##2 !IRQ_O)
        else $error("interrupt high with all masked");
endmodule
bind programmable_threshold_stages prog_stage_asserts u_asserts (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .START_O(START_O), .OPERATE_O(OPERATE_O),
    .IRQ_O(IRQ_O));
`default_nettype wire

// ---- sim/meas_model.sv ----
// measurement source model: one held value per selectable quantity
// assumes the bench loads values one at a time on the system clock
`timescale 1ns/1ps
`default_nettype none
module meas_model
    import prog_stage_pkg::*;
(
    input wire logic clk_i,
    input wire logic set_i,
    input wire logic [SEL_W-1:0] idx_i,
    input wire logic [MEAS_W-1:0] val_i,
    output logic [NUM_QTY*MEAS_W-1:0] meas_o
);
    logic [MEAS_W-1:0] qty_ff [NUM_QTY];
    initial
    begin
        foreach (qty_ff[k]) qty_ff[k] = '0;
    end
    always @(posedge clk_i)
    begin
        if (set_i && idx_i < NUM_QTY)
            qty_ff[idx_i] <= val_i;
    end
    always_comb
    begin
        for (int k = 0; k < NUM_QTY; k++)
            meas_o[k*MEAS_W +: MEAS_W] = qty_ff[k];
    end
endmodule
`default_nettype wire

// ---- sim/programmable_threshold_stages_tb_top.sv ----
// self-checking bench for the threshold stage bank
// assumes a shortened base tick of 20 clocks
`timescale 1ns/1ps
`default_nettype none
module programmable_threshold_stages_tb_top
    import prog_stage_pkg::*;
;
    localparam int T = 20;
    logic clk, rst_n, wr_en, rd_en, irq, m_set, e;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [NUM_STAGES-1:0] start, oper;
    logic [SEL_W-1:0] m_idx;
    logic [MEAS_W-1:0] m_val;
    logic [NUM_QTY*MEAS_W-1:0] meas;
    logic [1:0] m;
    int failures, n_checks, s, g, n, va, vb, lim, qa;
    int hv[7] = '{101, 95, 90, 50, 105, 10, 15};
    logic he[7] = '{1, 1, 0, 1, 1, 0, 0};
    logic [ADDR_W-1:0] ra[5] = '{CTRL_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS,
        STATE_OFS, 10'h010};
    programmable_threshold_stages #(.BASE_TICK_CYCLES_P(T)) dut (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_en), .REG_RD_I(rd_en),
        .MEAS_DATA_I(meas), .REG_RDATA_O(rdata), .START_O(start),
        .OPERATE_O(oper), .IRQ_O(irq));
    meas_model u_meas (.clk_i(clk), .set_i(m_set), .idx_i(m_idx),
        .val_i(m_val), .meas_o(meas));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] ex, got, input string nm);
        n_checks++;
        if (got !== ex)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ex);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        chk(ex, rdata, "rdata");
    endtask
    task automatic setq(input int q, input int v);
        m_idx <= SEL_W'(q);
        m_val <= MEAS_W'(v);
        m_set <= 1'b1;
        @(posedge clk);
        m_set <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_hi(input logic op, input int k, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            cnt++;
        end
        while ((op ? oper[k] : start[k]) !== 1'b1 && cnt < 900);
        if (cnt >= 900)
        begin
            chk(1, 0, "timeout");
            end_sim;
        end
    endtask
    function automatic logic [ADDR_W-1:0] ca(input int st, gr, w);
        return ADDR_W'(32'h200 + st * 64 + gr * 16 + w * 4);
    endfunction
    function automatic logic fresh(input logic [1:0] md, input int a, b,
        input int l, f);
        int df;
        df = a - b;
        case (md)
            2'h0: return a > l;
            2'h1: return a < l && a >= f;
            2'h2: return df > 0 && df > l;
            default: return (df < 0 ? -df : df) > l;
        endcase
    endfunction
    task automatic cfg(input int st, gr, md, cy, tb, sa, sb, l, h, dl, f);
        wr(CTRL_OFS, 32'h0);
        wr(ca(st, gr, 0), {10'h0, 6'(sb), 2'h0, 6'(sa), 1'b0, 3'(tb),
            2'(cy), 2'(md)});
        wr(ca(st, gr, 1), {16'h0, 16'(l)});
        wr(ca(st, gr, 2), {16'h0, 16'(h)});
        wr(ca(st, gr, 3), {16'(f), 16'(dl)});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(78156));
        {rst_n, wr_en, rd_en, m_set, addr, wdata, m_idx, m_val} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) rd(ra[i], 32'h0);
        wr(10'h010, 32'hFFFF_FFFF);
        rd(10'h010, 32'h0);
        wr(CTRL_OFS, 32'hFFFF_FFFF);
        rd(CTRL_OFS, 32'h0000_03FF);
        for (int i = 0; i < 6; i++)
        begin
            addr <= ca($urandom_range(7), $urandom_range(3), i % 4);
            @(posedge clk);
            d = $urandom;
            wr(addr, d);
            rd(addr, d);
            rd(addr | 10'h001, 32'h0);
        end
        for (int i = 0; i < 16; i++)
        begin
            s = $urandom_range(7);
            g = $urandom_range(3);
            m = 2'(i);
            qa = $urandom_range(NUM_QTY - 1);
            va = int'($urandom_range(2000)) - 1000;
            vb = int'($urandom_range(2000)) - 1000;
            lim = int'($urandom_range(600)) - 300;
            cfg(s, g, m, 0, 0, qa, (qa + 1) % NUM_QTY, lim, 20, 0, -400);
            setq(qa, va);
            setq((qa + 1) % NUM_QTY, vb);
            wr(CTRL_OFS, {22'h0, 2'(g), 8'h01 << s});
            repeat (2 * T + 5) @(posedge clk);
            e = fresh(m, va, m > 1 ? vb : 0, lim, -400);
            chk({e, e}, {oper[s], start[s]}, "mode");
        end
        for (int i = 0; i < 7; i++)
        begin
            if (i % 3 == 0)
            begin
                cfg(2, 1, i > 0, 0, 0, 5, 6, 100, 10, 0, 20);
                wr(CTRL_OFS, 32'h0000_0104);
            end
            setq(5, hv[i]);
            repeat (2 * T + 5) @(posedge clk);
            chk(he[i], start[2], "hyst");
        end
        for (int c = 0; c < 4; c++)
        begin
            cfg(3, 0, 0, c, 0, 8, 9, 100, 0, 2, 0);
            setq(8, 500);
            wr(CTRL_OFS, 32'h0000_0008);
            wait_hi(1'b0, 3, n);
            wait_hi(1'b1, 3, n);
            chk(2 * T * (c == 0 ? 1 : c == 1 ? MID_DIV : SLOW_DIV), n,
                "delay");
        end
        cfg(4, 0, 0, 0, 2, 7, 8, 500, 0, 0, 0);
        setq(7, 0);
        wr(CTRL_OFS, 32'h0000_0010);
        repeat (12 * T) @(posedge clk);
        setq(7, 1000);
        repeat (T + 5) @(posedge clk);
        chk(0, start[4], "avg early");
        repeat (5 * T) @(posedge clk);
        chk(1, start[4], "avg late");
        cfg(5, 0, 0, 0, 0, 9, 10, 100, 0, 0, 0);
        wr(IRQ_STATUS_OFS, 32'h0000_FFFF);
        wr(IRQ_MASK_OFS, 32'h0000_0020);
        setq(9, 200);
        wr(CTRL_OFS, 32'h0000_0020);
        repeat (2 * T + 5) @(posedge clk);
        chk(1, irq, "irq");
        rd(STATE_OFS, 32'h0000_2020);
        rd(IRQ_STATUS_OFS, 32'h0000_2020);
        wr(IRQ_MASK_OFS, 32'h0);
        repeat (3) @(posedge clk);
        chk(0, irq, "irq masked");
        wr(IRQ_MASK_OFS, 32'h0000_0020);
        repeat (3) @(posedge clk);
        chk(1, irq, "irq unmasked");
        wr(IRQ_STATUS_OFS, 32'h0000_0020);
        repeat (3) @(posedge clk);
        chk(0, irq, "irq cleared");
        rd(IRQ_STATUS_OFS, 32'h0000_2000);
        end_sim;
    end
endmodule
`default_nettype wire
